// File: dv/fcq_flash_model.sv
// behavioural flash device facing the controller
`timescale 1ns/100ps
module fcq_flash_model #(
	parameter logic [7:0] SECT2 = 8'h1F,
	parameter logic [7:0] BOOT = 8'h02,
	parameter logic [15:0] MAKER = 16'h005A, // arbitrary
	parameter logic [15:0] DEVID = 16'h2B3C // arbitrary
) (
	input wire fcq_pkg::fcq_pins_t pins_i,
	input wire logic rst_n_i,
	input wire logic busy_i,
	output logic [15:0] dq_o,
	output logic ready_o
);
	import fcq_pkg::*;
	logic [1:0] mode = 2'h0;
	logic [1:0] step = 2'h0;
	logic act = 1'b0;
	// query mode was entered from autoselect
	logic qa = 1'b0;
	logic [19:0] la;
	logic [15:0] rd;
	logic [15:0] last = 16'h0;
	wire [19:0] a = pins_i.addr;
	// ****
	// read side
	// ****
	function automatic logic [15:0] qry(input logic [7:0] x);
		case (x)
		8'h27: return 16'h0016;
		8'h28, 8'h2C, 8'h46: return 16'h0002;
		8'h2D: return 16'h0007;
		8'h2F: return 16'h0020;
		8'h31: return 16'h003E;
		8'h34, 8'h45, 8'h47, 8'h48: return 16'h0001;
		8'h40: return 16'h0050;
		8'h41: return 16'h0052;
		8'h42: return 16'h0049;
		8'h43: return 16'h0031;
		8'h44: return 16'h0033;
		8'h49: return 16'h0004;
		8'h4A: return {8'h00, SECT2};
		8'h4D: return 16'h0085;
		8'h4E: return 16'h0095;
		8'h4F: return {8'h00, BOOT};
		default: return 16'h0000;
		endcase
	endfunction
	always_comb begin
		case (mode)
		2'h0: rd = a[15:0] ^ 16'hA5A5;
		2'h1: rd = qry(a[7:0]);
		2'h2: rd = (a[7:0] == 8'h00) ? MAKER : (a[7:0] == 8'h01) ? DEVID : {15'h0, a[12]};
		default: rd = a[15:0] ^ 16'h3C3C;
		endcase
	end
	// released bus shows the inverse of the last word
	assign dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? rd : ~last;
	assign ready_o = !busy_i;
	always @(posedge pins_i.oe_n) last = rd;
	// ****
	// command decoder
	// ****
	task automatic cmd(input logic [19:0] x, input logic [15:0] d);
		if (d == 16'h00F0 && mode != 2'h3) begin
			// a query entered from autoselect falls back to autoselect
			mode = (mode == 2'h1 && qa) ? 2'h2 : 2'h0;
			qa = 1'b0;
			step = 2'h0;
		end else if (x == 20'h00055 && d == 16'h0098) begin
			qa = (mode == 2'h2);
			mode = 2'h1;
		end else if (step == 2'h0 && x[10:0] == 11'h555 && d == 16'h00AA) begin
			step = 2'h1;
		end else if (step == 2'h1 && x[10:0] == 11'h2AA && d == 16'h0055) begin
			step = 2'h2;
		end else if (step == 2'h2 && x[10:0] == 11'h555 && d == 16'h0088 && !busy_i) begin
			mode = 2'h3;
			step = 2'h0;
		end else if (step == 2'h2 && d == 16'h0090 && mode == 2'h3) begin
			step = 2'h3;
		end else if (step == 2'h2 && d == 16'h0090 && !busy_i) begin
			mode = 2'h2;
			step = 2'h0;
		end else if (step == 2'h3 && d == 16'h0000) begin
			mode = 2'h0;
			step = 2'h0;
		end else begin
			step = 2'h0;
			if (mode != 2'h3) mode = 2'h0;
		end
	endtask
	always @(negedge pins_i.we_n or negedge pins_i.ce_n) begin
		if (!pins_i.we_n && !pins_i.ce_n && pins_i.oe_n) begin
			la = a;
			act = 1'b1;
		end
	end
	always @(posedge pins_i.we_n or posedge pins_i.ce_n) begin
		if (act) begin
			act = 1'b0;
			cmd(la, pins_i.dq);
		end
	end
	always @(negedge rst_n_i) begin
		mode = 2'h0;
		qa = 1'b0;
		step = 2'h0;
	end
endmodule

// File: dv/fcq_host_assertions.sv
// concurrent checks on the flash command controller ports
`timescale 1ns/100ps
module fcq_host_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire fcq_pkg::fcq_pins_t flash_o,
	input wire logic flash_rst_n_o
);
	import fcq_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****
	// bus and pin timing
	// ****
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("data outside ack");
	a_write_qualified: assert property (!flash_o.we_n |-> !flash_o.ce_n && flash_o.oe_n && flash_o.dq_oe)
		else $error("write strobe unqualified");
	a_strobe_width: assert property ($fell(flash_o.we_n) |=> !flash_o.we_n ##1 flash_o.we_n)
		else $error("write strobe width");
	a_addr_hold: assert property (!flash_o.ce_n && !$past(flash_o.ce_n) |-> $stable(flash_o.addr) && $stable(flash_o.dq))
		else $error("address or data moved");
	a_dq_release: assert property ($rose(flash_o.ce_n) |-> !flash_o.dq_oe)
		else $error("data bus not released");
	a_read_width: assert property ($fell(flash_o.oe_n) |=> !flash_o.oe_n [*3] ##1 flash_o.oe_n)
		else $error("read strobe width");
	a_rst_width: assert property ($fell(flash_rst_n_o) |=> !flash_rst_n_o [*4] ##1 flash_rst_n_o)
		else $error("reset pulse width");
	c_write: cover property ($fell(flash_o.we_n));
	c_read: cover property ($fell(flash_o.oe_n));
	c_hw_reset: cover property ($fell(flash_rst_n_o));
endmodule
bind fcq_host fcq_host_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_o(flash_o), .flash_rst_n_o(flash_rst_n_o));

// File: dv/tb_top.sv
// self-checking bench of the flash command controller
`timescale 1ns/100ps
module tb_top;
	import fcq_pkg::*;
	localparam logic [7:0] SECT2 = 8'h1C;
	localparam logic [7:0] BOOT = 8'h03;
	localparam logic [15:0] MAKER = 16'h005A; // arbitrary
	localparam logic [15:0] DEVID = 16'h2B3C; // arbitrary
	localparam logic [7:0] QA [0:20] = '{8'h27, 8'h2C, 8'h2D, 8'h2F, 8'h31, 8'h34, 8'h38, 8'h40, 8'h41, 8'h42,
		8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h49, 8'h4A, 8'h4B, 8'h4D, 8'h4E, 8'h4F};
	localparam logic [15:0] QV [0:20] = '{16'h16, 16'h2, 16'h7, 16'h20, 16'h3E, 16'h1, 16'h0, 16'h50, 16'h52,
		16'h49, 16'h31, 16'h33, 16'h1, 16'h2, 16'h1, 16'h4, {8'h0, SECT2}, 16'h0, 16'h85, 16'h95, {8'h0, BOOT}};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'hF;
	logic busy = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	fcq_pins_t flash_o;
	logic [15:0] mdq;
	logic ready;
	logic rst_n;
	int n_errors = 0;
	int checks_done = 0;
	wire [15:0] dq = flash_o.dq_oe ? flash_o.dq : mdq;
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	fcq_host #(.READY_CYC(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.flash_o(flash_o), .flash_dq_i(dq), .flash_ready_i(ready), .flash_rst_n_o(rst_n));
	fcq_flash_model #(.SECT2(SECT2), .BOOT(BOOT), .MAKER(MAKER), .DEVID(DEVID)) flash_u (.pins_i(flash_o),
		.rst_n_i(rst_n), .busy_i(busy), .dq_o(mdq), .ready_o(ready));
	// ****
	// bus tasks
	// ****
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (i >= 50) begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic op(input logic [2:0] c, input logic [19:0] a);
		logic [31:0] s;
		int i;
		wb(1'b1, 8'h04, {12'h0, a}, s);
		wb(1'b1, 8'h00, {29'h0, c}, s);
		i = 0;
		do begin
			wb(1'b0, 8'h10, 32'h0, s);
			i++;
		end while (s[0] !== 1'b0 && i < 100);
		if (i >= 100) begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic raw(input logic [19:0] a, input logic [15:0] d);
		logic [31:0] s;
		wb(1'b1, 8'h08, {16'h0, d}, s);
		op(3'h6, a);
	endtask
	task automatic rd(input string nm, input logic [19:0] a, input logic [31:0] e);
		logic [31:0] q;
		op(3'h0, a);
		wb(1'b0, 8'h0C, 32'h0, q);
		chk(nm, e, q);
	endtask
	task automatic st(input string nm, input logic [31:0] e);
		logic [31:0] s;
		wb(1'b0, 8'h10, 32'h0, s);
		chk(nm, e, s);
	endtask
	function automatic logic [31:0] arr(input logic [19:0] a);
		return {16'h0, a[15:0] ^ 16'hA5A5};
	endfunction
	// ****
	// scenarios
	// ****
	initial begin
		logic [31:0] q;
		logic [19:0] a;
		logic [7:0] b;
		void'($urandom(32'h01b10717));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		st("status", 32'h10);
		wb(1'b1, 8'h14, 32'hFFFFFFFF, q);
		wb(1'b0, 8'h14, 32'h0, q);
		chk("unmapped", 32'h0, q);
		for (int k = 0; k < 4; k++) begin
			a = 20'($urandom);
			rd("array", a, arr(a));
		end
		$display("reset test done");
		op(3'h2, 20'h0);
		st("query mode", 32'h14);
		foreach (QA[k]) begin
			rd("query word", {12'h0, QA[k]}, {16'h0, QV[k]});
		end
		a = 20'($urandom);
		op(3'h1, a);
		st("reset mode", 32'h10);
		rd("array", a, arr(a));
		$display("query test done");
		b = 8'($urandom);
		op(3'h3, {b, 12'h0});
		st("autoselect mode", 32'h18);
		rd("maker", {b, 12'h000}, {16'h0, MAKER});
		rd("device", {b, 12'h001}, {16'h0, DEVID});
		rd("protect", {b, 12'h002}, {31'h0, b[0]});
		op(3'h2, 20'h0);
		st("query from autoselect", 32'h34);
		rd("query word", 20'h00027, 32'h16);
		op(3'h1, 20'h0);
		st("back to autoselect", 32'h18);
		rd("maker", {b, 12'h000}, {16'h0, MAKER});
		op(3'h1, 20'h0);
		rd("array", a, arr(a));
		$display("autoselect test done");
		raw(20'h00555, 16'h00AA);
		raw(20'h002AA, 16'h0055);
		raw(20'h00123, 16'h0033);
		raw(20'h00555, 16'h0090);
		rd("abandoned", a, arr(a));
		$display("abort test done");
		raw(20'h00555, 16'h00AA);
		raw(20'h002AA, 16'h0055);
		op(3'h1, 20'h0);
		raw(20'h00555, 16'h0090);
		rd("cancelled", a, arr(a));
		$display("cancel test done");
		op(3'h4, 20'h0);
		st("secure mode", 32'h1C);
		rd("secure", a, {16'h0, a[15:0] ^ 16'h3C3C});
		op(3'h1, 20'h0);
		st("still secure", 32'h1C);
		op(3'h5, 20'h0);
		rd("array", a, arr(a));
		busy <= 1'b1;
		repeat (4) @(posedge clk_i);
		op(3'h4, 20'h0);
		st("refused", 32'h02);
		wb(1'b1, 8'h10, 32'h2, q);
		busy <= 1'b0;
		repeat (4) @(posedge clk_i);
		st("cleared", 32'h10);
		$display("secure test done");
		op(3'h4, 20'h0);
		op(3'h7, 20'h0);
		st("hw reset mode", 32'h10);
		rd("array", a, arr(a));
		sel <= 4'h1;
		wb(1'b1, 8'h04, 32'hFFFFFFFF, q);
		sel <= 4'hF;
		wb(1'b0, 8'h04, 32'h0, q);
		chk("addr lanes", {12'h0, a[19:8], 8'hFF}, q);
		$display("hw reset test done");
		conclude();
	end
endmodule

// File: hw/fcq_cycle.sv
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/100ps
`include "fcq_map.svh"

module fcq_cycle (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire fcq_pkg::fcq_step_t step_i,
	input wire logic [15:0] dq_i,
	output fcq_pkg::fcq_pins_t pins_o,
	output logic [15:0] rdata_o,
	output logic done_o
);
	import fcq_pkg::*;

	localparam logic [3:0] WR_CNT = 4'(`FCQ_WP_CYC);
	localparam logic [3:0] RD_CNT = 4'(`FCQ_ACC_CYC + `FCQ_SYNC_CYC);
	localparam logic [3:0] GAP_CNT = 4'(`FCQ_WPH_CYC);

	fcq_cyc_t state;
	logic rd;
	logic [3:0] cnt;
	logic [15:0] dq_meta;
	logic [15:0] dq_sync;
	wire cnt_zero = (cnt == 4'h0);

	// ****************************************
	// data pins pass two flip-flops before use
	// ****************************************
	always_ff @(posedge clk_i) begin
		dq_meta <= dq_i;
		dq_sync <= dq_meta;
	end

	// ****************************************
	// cycle sequence: chip select first, strobe, release
	// ****************************************
	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		if (rst_i) begin
			state <= CY_IDLE;
			pins_o <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: `FCQ_ADDR_RST, dq: `FCQ_DATA_RST, dq_oe: 1'b0};
			rd <= 1'b0;
			cnt <= 4'h0;
			rdata_o <= `FCQ_DATA_RST;
		end else begin
			unique case (state)
				CY_IDLE: begin
					if (start_i) begin
						// address and chip select settle before the strobe falls
						pins_o.ce_n <= 1'b0;
						pins_o.addr <= step_i.addr;
						pins_o.dq <= step_i.data;
						pins_o.dq_oe <= ~step_i.rd;
						rd <= step_i.rd;
						state <= CY_SETUP;
					end
				end
				CY_SETUP: begin
					pins_o.we_n <= rd;
					pins_o.oe_n <= ~rd;
					cnt <= rd ? RD_CNT : WR_CNT;
					state <= CY_STROBE;
				end
				CY_STROBE: begin
					if (cnt_zero) begin
						// write strobe rises first so data is taken on it
						pins_o.we_n <= 1'b1;
						pins_o.oe_n <= 1'b1;
						if (rd) begin
							rdata_o <= dq_sync;
						end
						cnt <= GAP_CNT;
						state <= CY_HOLD;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				CY_HOLD: begin
					pins_o.ce_n <= 1'b1;
					pins_o.dq_oe <= 1'b0;
					if (cnt_zero) begin
						done_o <= 1'b1;
						state <= CY_IDLE;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
			endcase
		end
	end
endmodule

// File: hw/fcq_host.sv
// host controller issuing command sequences and reads to a dual-bank parallel flash
//
// Summary of operation
// - query mode entered by writing 98h to word address 55h from read mode.
// - host writes reset after a timeout error or to leave autoselect.
// - autoselect only from read mode and never while the device is busy.
// - autoselect entry is two unlock cycles then bank address with command.
// - three-cycle entry to secure region, four-cycle exit; entry refused while busy.
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "fcq_map.svh"

module fcq_host #(
	parameter int READY_CYC = `FCQ_READY_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output fcq_pkg::fcq_pins_t flash_o,
	input wire logic [15:0] flash_dq_i,
	input wire logic flash_ready_i,
	output logic flash_rst_n_o
);
	import fcq_pkg::*;

	fcq_state_t state;
	fcq_mode_t mode;
	fcq_op_t op;
	logic [1:0] idx;
	logic [19:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic refused;
	logic from_auto;
	logic ready_meta;
	logic ready_sync;
	logic [15:0] cnt;
	logic cyc_start;
	logic cyc_done;
	logic [15:0] cyc_rdata;
	fcq_step_t step;

	// ****************************************
	// command sequences, one step per flash cycle
	// ****************************************
	function automatic fcq_step_t step_of(fcq_op_t o, logic [1:0] i, logic [19:0] a, logic [15:0] d);
		fcq_step_t s;
		s = '{last: 1'b0, rd: 1'b0, addr: `FCQ_UNLOCK1_ADDR, data: `FCQ_UNLOCK1_DATA};
		if (i == 2'h1) begin
			s.addr = `FCQ_UNLOCK2_ADDR;
			s.data = `FCQ_UNLOCK2_DATA;
		end
		case (o)
			OP_READ: s = '{last: 1'b1, rd: 1'b1, addr: a, data: d};
			OP_WRITE: s = '{last: 1'b1, rd: 1'b0, addr: a, data: d};
			OP_RESET: s = '{last: 1'b1, rd: 1'b0, addr: a, data: `FCQ_RESET_DATA};
			OP_QUERY: s = '{last: 1'b1, rd: 1'b0, addr: `FCQ_QUERY_ADDR, data: `FCQ_QUERY_DATA};
			OP_AUTOSEL: if (i == 2'h2) begin
				// bank address carried with the command
				s = '{last: 1'b1, rd: 1'b0, addr: (a & `FCQ_BANK_MASK) | `FCQ_UNLOCK1_ADDR, data: `FCQ_AUTOSEL_DATA};
			end
			OP_SEC_ENTER: if (i == 2'h2) begin
				s = '{last: 1'b1, rd: 1'b0, addr: `FCQ_UNLOCK1_ADDR, data: `FCQ_SECURE_DATA};
			end
			OP_SEC_EXIT: begin
				if (i == 2'h2) begin
					s.data = `FCQ_AUTOSEL_DATA;
				end
				if (i == 2'h3) begin
					s = '{last: 1'b1, rd: 1'b0, addr: a, data: `FCQ_EXIT_DATA};
				end
			end
			default: s.last = 1'b1;
		endcase
		return s;
	endfunction

	// byte-lane merge for software writes
	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************
	// register bus decode
	// ****************************************
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i;
	wire busy = (state != ST_IDLE);
	wire wr_ctrl = bus_wr & (wb_adr_i == `FCQ_REG_CTRL) & wb_sel_i[0];
	wire wr_addr = bus_wr & (wb_adr_i == `FCQ_REG_ADDR) & ~busy;
	wire wr_wdata = bus_wr & (wb_adr_i == `FCQ_REG_WDATA) & ~busy;
	wire clr_refused = bus_wr & (wb_adr_i == `FCQ_REG_STATUS) & wb_sel_i[0] & wb_dat_i[`FCQ_ST_REFUSED];
	wire fcq_op_t req_op = fcq_op_t'(wb_dat_i[2:0]);
	// autoselect only from read mode, query from read or autoselect mode, both only on a ready device
	wire auto_bad = (req_op == OP_AUTOSEL) & (~ready_sync | (mode != MODE_ARRAY));
	wire query_bad = (req_op == OP_QUERY) & (~ready_sync | ((mode != MODE_ARRAY) & (mode != MODE_AUTOSEL)));
	wire sec_bad = (req_op == OP_SEC_ENTER) & (~ready_sync | (mode != MODE_ARRAY));
	wire start_ok = wr_ctrl & ~busy & ~auto_bad & ~query_bad & ~sec_bad;
	wire refuse = wr_ctrl & ~start_ok;
	wire [31:0] addr_next = merge({12'h000, addr}, wb_dat_i, wb_sel_i);
	wire [31:0] wdata_next = merge({16'h0000, wdata}, wb_dat_i, wb_sel_i);
	wire [31:0] status_word = {26'h0, from_auto, ready_sync, mode, refused, busy};
	wire [31:0] rd_word = (wb_adr_i == `FCQ_REG_CTRL) ? {29'h0, op} :
		(wb_adr_i == `FCQ_REG_ADDR) ? {12'h000, addr} :
		(wb_adr_i == `FCQ_REG_WDATA) ? {16'h0000, wdata} :
		(wb_adr_i == `FCQ_REG_RDATA) ? {16'h0000, rdata} :
		(wb_adr_i == `FCQ_REG_STATUS) ? status_word : 32'h00000000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_word : 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		ready_meta <= flash_ready_i;
		ready_sync <= ready_meta;
	end

	// ****************************************
	// software-written registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr <= `FCQ_ADDR_RST;
			wdata <= `FCQ_DATA_RST;
			refused <= 1'b0;
		end else begin
			if (wr_addr) begin
				addr <= addr_next[19:0];
			end
			if (wr_wdata) begin
				wdata <= wdata_next[15:0];
			end
			// a new refusal wins over a clear in the same cycle
			refused <= refuse | (refused & ~clr_refused);
		end
	end

	// ****************************************
	// sequencer over flash cycles and the reset pin
	// ****************************************
	assign step = step_of(op, idx, addr, wdata);
	assign cyc_start = (state == ST_ISSUE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			op <= OP_READ;
			idx <= 2'h0;
			cnt <= 16'h0000;
			mode <= MODE_ARRAY;
			from_auto <= 1'b0;
			rdata <= `FCQ_DATA_RST;
			flash_rst_n_o <= 1'b1;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start_ok) begin
						op <= req_op;
						idx <= 2'h0;
						cnt <= 16'(`FCQ_RP_CYC);
						state <= (req_op == OP_HW_RESET) ? ST_RST_LOW : ST_ISSUE;
						flash_rst_n_o <= (req_op != OP_HW_RESET);
					end
				end
				ST_ISSUE: state <= ST_WAIT;
				ST_WAIT: begin
					if (cyc_done) begin
						idx <= idx + 2'h1;
						state <= step.last ? ST_IDLE : ST_ISSUE;
						if (step.last) begin
							unique case (op)
								// query words carry their value on the low byte
								OP_READ: rdata <= (mode == MODE_QUERY) ? {8'h00, cyc_rdata[7:0]} : cyc_rdata;
								OP_QUERY: begin
									from_auto <= (mode == MODE_AUTOSEL);
									mode <= MODE_QUERY;
								end
								OP_RESET: begin
									// leave autoselect or a query entered from it
									mode <= (mode == MODE_QUERY && from_auto) ? MODE_AUTOSEL :
										(mode == MODE_SECURE) ? MODE_SECURE : MODE_ARRAY;
									from_auto <= 1'b0;
								end
								OP_AUTOSEL: mode <= MODE_AUTOSEL;
								OP_SEC_ENTER: mode <= MODE_SECURE;
								OP_SEC_EXIT: mode <= MODE_ARRAY;
								default: mode <= mode;
							endcase
						end
					end
				end
				ST_RST_LOW: begin
					if (cnt == 16'h0001) begin
						flash_rst_n_o <= 1'b1;
						cnt <= 16'(READY_CYC);
						mode <= MODE_ARRAY;
						from_auto <= 1'b0;
						state <= ST_RST_REC;
					end else begin
						cnt <= cnt - 16'h0001;
					end
				end
				ST_RST_REC: begin
					if (cnt == 16'h0001) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt - 16'h0001;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	fcq_cycle u_cycle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(cyc_start),
		.step_i(step),
		.dq_i(flash_dq_i),
		.pins_o(flash_o),
		.rdata_o(cyc_rdata),
		.done_o(cyc_done)
	);
endmodule

// File: hw/fcq_map.svh
// register offsets, command codes and timing counts of the flash command controller
`ifndef FCQ_MAP_SVH
`define FCQ_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define FCQ_REG_CTRL 8'h00
`define FCQ_REG_ADDR 8'h04
`define FCQ_REG_WDATA 8'h08
`define FCQ_REG_RDATA 8'h0C
`define FCQ_REG_STATUS 8'h10

// ****************************************
// status fields and reset values
// ****************************************
`define FCQ_ST_BUSY 0
`define FCQ_ST_REFUSED 1
`define FCQ_ST_MODE_LO 2
`define FCQ_ST_READY 4
`define FCQ_ST_FROM_AUTO 5
`define FCQ_ADDR_RST 20'h00000
`define FCQ_DATA_RST 16'h0000

// ****************************************
// command words and unlock addresses (word mode)
// ****************************************
`define FCQ_UNLOCK1_ADDR 20'h00555
`define FCQ_UNLOCK2_ADDR 20'h002AA
`define FCQ_UNLOCK1_DATA 16'h00AA
`define FCQ_UNLOCK2_DATA 16'h0055
`define FCQ_QUERY_ADDR 20'h00055
`define FCQ_QUERY_DATA 16'h0098
`define FCQ_RESET_DATA 16'h00F0
`define FCQ_AUTOSEL_DATA 16'h0090
`define FCQ_SECURE_DATA 16'h0088
`define FCQ_EXIT_DATA 16'h0000
`define FCQ_BANK_MASK 20'hFF000

// ****************************************
// timing: times in ns, counts in 100 ns cycles
// ****************************************
`define FCQ_CLK_NS 100
`define FCQ_T_WP_NS 35
`define FCQ_T_ACC_NS 70
`define FCQ_T_WPH_NS 30
`define FCQ_T_RP_NS 500
`define FCQ_T_READY_NS 20000
`define FCQ_CYC(ns) (((ns) + `FCQ_CLK_NS - 1) / `FCQ_CLK_NS)
`define FCQ_WP_CYC `FCQ_CYC(`FCQ_T_WP_NS)
`define FCQ_ACC_CYC `FCQ_CYC(`FCQ_T_ACC_NS)
`define FCQ_WPH_CYC `FCQ_CYC(`FCQ_T_WPH_NS)
`define FCQ_RP_CYC `FCQ_CYC(`FCQ_T_RP_NS)
`define FCQ_READY_CYC `FCQ_CYC(`FCQ_T_READY_NS)
`define FCQ_SYNC_CYC 2

`endif

// File: hw/fcq_pkg.sv
// types of the flash command controller
package fcq_pkg;

	// flash pins driven by the controller, all from flip-flops
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [19:0] addr;
		logic [15:0] dq;
		logic dq_oe;
	} fcq_pins_t;

	typedef struct packed {
		logic last;
		logic rd;
		logic [19:0] addr;
		logic [15:0] data;
	} fcq_step_t;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_RESET = 3'h1,
		OP_QUERY = 3'h2,
		OP_AUTOSEL = 3'h3,
		OP_SEC_ENTER = 3'h4,
		OP_SEC_EXIT = 3'h5,
		OP_WRITE = 3'h6,
		OP_HW_RESET = 3'h7
	} fcq_op_t;

	typedef enum logic [1:0] {
		MODE_ARRAY = 2'h0,
		MODE_QUERY = 2'h1,
		MODE_AUTOSEL = 2'h2,
		MODE_SECURE = 2'h3
	} fcq_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ISSUE = 3'h1,
		ST_WAIT = 3'h2,
		ST_RST_LOW = 3'h3,
		ST_RST_REC = 3'h4
	} fcq_state_t;

	typedef enum logic [1:0] {
		CY_IDLE = 2'h0,
		CY_SETUP = 2'h1,
		CY_STROBE = 2'h2,
		CY_HOLD = 2'h3
	} fcq_cyc_t;

endpackage
